// ==== src/led_pwm_latch_control.sv ====
/*
 * Shift register, idle-based latch pulse, two-entry latch buffer, control latch and grayscale PWM.
 * Assumes shift clock and data arrive asynchronously on pins and reset is synchronous, active low.
 */
`timescale 1ns/1ps
`include "led_pwm_params.svh"

module led_pwm_latch_control #(
    parameter int IDLE_MAX = `IDLE_MAX_PERIODS,
    parameter int OSC_DIV  = `OSC_PERIOD_CYC
) (
    // Clock and reset.
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // Serial link.
    input  wire logic                 shift_clock_in,
    input  wire logic                 serial_data_in,
    output logic                      serial_data_out,
    // Channel drive.
    output logic [2:0]                current_sink_output,
    // Brightness levels per colour group.
    output led_pwm_pkg::bright_t      red_group_brightness,
    output led_pwm_pkg::bright_t      green_group_brightness,
    output led_pwm_pkg::bright_t      blue_group_brightness,
    // Status.
    output logic                      display_blanked,
    output logic                      latch_pulse
);
    import led_pwm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and internal oscillator.
    logic [2:0]           sck_sync;
    logic [2:0]           sdi_sync;
    logic                 sck_lvl;
    logic                 sdi_lvl;
    logic [`OSC_CNT_W-1:0] osc_cnt;
    logic                 next_sck_lvl;
    logic                 next_sdi_lvl;
    logic [`OSC_CNT_W-1:0] next_osc_cnt;
    logic                 sck_rise;
    logic                 osc_tick;
    logic                 osc_lvl;

    always_comb begin
        next_sck_lvl = (sck_sync[1] == sck_sync[2]) ? sck_sync[2] : sck_lvl;
        next_sdi_lvl = (sdi_sync[1] == sdi_sync[2]) ? sdi_sync[2] : sdi_lvl;
        sck_rise     = (sck_sync[1] == sck_sync[2]) && sck_sync[2] && !sck_lvl;
        osc_tick     = (osc_cnt == `OSC_CNT_W'(OSC_DIV - 1));
        osc_lvl      = (osc_cnt >= `OSC_CNT_W'(OSC_DIV / 2));
        next_osc_cnt = osc_tick ? '0 : osc_cnt + `OSC_CNT_W'(1);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sck_sync <= 3'h0;
            sdi_sync <= 3'h0;
            sck_lvl  <= 1'b0;
            sdi_lvl  <= 1'b0;
            osc_cnt  <= '0;
        end else begin
            sck_sync <= {sck_sync[1:0], shift_clock_in};
            sdi_sync <= {sdi_sync[1:0], serial_data_in};
            sck_lvl  <= next_sck_lvl;
            sdi_lvl  <= next_sdi_lvl;
            osc_cnt  <= next_osc_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift register and idle detection.
    shift_word_t          shift_reg;
    logic [`IVAL_W-1:0]   ival_cnt;
    logic [`IVAL_W-1:0]   last_ival;
    logic [`THR_W-1:0]    idle_cnt;
    logic                 armed;
    shift_word_t          next_shift_reg;
    logic [`IVAL_W-1:0]   next_ival_cnt;
    logic [`IVAL_W-1:0]   next_last_ival;
    logic [`THR_W-1:0]    next_idle_cnt;
    logic                 next_armed;
    logic [`THR_W-1:0]    idle_thr;
    logic                 idle_done;
    logic                 cmd_ok;
    logic                 push;
    logic                 buf_full;

    always_comb begin
        idle_thr = {3'h0, last_ival} << `IDLE_MULT_SHIFT; // [R11]
        if (idle_thr < `THR_W'(`IDLE_MIN_PERIODS)) begin
            idle_thr = `THR_W'(`IDLE_MIN_PERIODS); // [R12]
        end else if (idle_thr > `THR_W'(IDLE_MAX)) begin
            idle_thr = `THR_W'(IDLE_MAX); // [R12]
        end
        idle_done      = armed && (idle_cnt >= idle_thr);
        cmd_ok         = (shift_reg[`SHIFT_W-1 -: `CMD_W] == `CMD_CODE); // [R11]
        push           = idle_done && cmd_ok && !buf_full;
        next_shift_reg = shift_reg;
        next_ival_cnt  = ival_cnt;
        next_last_ival = last_ival;
        next_idle_cnt  = idle_cnt;
        next_armed     = armed;
        if (sck_rise) begin
            next_shift_reg = {shift_reg[`SHIFT_W-2:0], sdi_lvl}; // [R14]
            next_last_ival = ival_cnt; // [R17]
            next_ival_cnt  = '0;
            next_idle_cnt  = '0;
            next_armed     = 1'b1;
        end else begin
            if (osc_tick && (ival_cnt < `IVAL_W'(IDLE_MAX))) begin
                next_ival_cnt = ival_cnt + `IVAL_W'(1); // [R17]
            end
            if (osc_tick && (idle_cnt < `THR_W'(IDLE_MAX))) begin
                next_idle_cnt = idle_cnt + `THR_W'(1);
            end
            // A full buffer keeps the request armed until room appears.
            if (idle_done && (!cmd_ok || !buf_full)) begin
                next_armed = 1'b0; // [R15]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            shift_reg       <= '0;
            ival_cnt        <= '0;
            last_ival       <= '0;
            idle_cnt        <= '0;
            armed           <= 1'b0;
            serial_data_out <= 1'b0;
        end else begin
            shift_reg       <= next_shift_reg;
            ival_cnt        <= next_ival_cnt;
            last_ival       <= next_last_ival;
            idle_cnt        <= next_idle_cnt;
            armed           <= next_armed;
            serial_data_out <= next_shift_reg[`SHIFT_W-1]; // [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry latch buffer and control latch.
    latch_word_t          buf_mem [2];
    logic                 wr_ptr;
    logic                 rd_ptr;
    logic [1:0]           buf_cnt;
    latch_word_t          ctrl;
    logic                 next_wr_ptr;
    logic                 next_rd_ptr;
    logic [1:0]           next_buf_cnt;
    latch_word_t          next_ctrl;
    logic                 pop;
    logic                 gs_step;

    always_comb begin
        buf_full     = (buf_cnt == 2'h2);
        pop          = (buf_cnt != 2'h0) && !gs_step;
        next_wr_ptr  = push ? !wr_ptr : wr_ptr;
        next_rd_ptr  = pop ? !rd_ptr : rd_ptr;
        next_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};
        next_ctrl    = pop ? buf_mem[rd_ptr] : ctrl; // [R13]
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            buf_mem[0]  <= '0;
            buf_mem[1]  <= '0;
            wr_ptr      <= 1'b0;
            rd_ptr      <= 1'b0;
            buf_cnt     <= 2'h0;
            ctrl        <= '0;
            ctrl[`BLANK_BIT] <= 1'b1; // [R4]
            latch_pulse <= 1'b0;
        end else begin
            if (push) begin
                buf_mem[wr_ptr] <= shift_reg[`LATCH_W-1:0]; // [R13]
            end
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            buf_cnt     <= next_buf_cnt;
            ctrl        <= next_ctrl;
            latch_pulse <= pop;
        end
    end

    assign red_group_brightness   = ctrl[`RED_BC_LSB +: `BC_W]; // [R2]
    assign green_group_brightness = ctrl[`GREEN_BC_LSB +: `BC_W]; // [R2]
    assign blue_group_brightness  = ctrl[`BLUE_BC_LSB +: `BC_W]; // [R2]
    assign display_blanked        = ctrl[`BLANK_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Grayscale counter and output timing.
    logic                 ref_prev;
    gray_t                gs_count;
    logic                 gs_done;
    logic [2:0]           next_out;
    gray_t                next_gs_count;
    logic                 next_gs_done;
    logic                 ref_lvl;
    gray_t                gray_val [3];

    always_comb begin
        gray_val[0]   = ctrl[`RED3_LSB +: `GS_W]; // [R1]
        gray_val[1]   = ctrl[`GREEN3_LSB +: `GS_W]; // [R1]
        gray_val[2]   = ctrl[`BLUE3_LSB +: `GS_W]; // [R1]
        ref_lvl       = ctrl[`CLKSEL_BIT] ? sck_lvl : osc_lvl; // [R9]
        gs_step       = ctrl[`EDGESEL_BIT] ? (ref_lvl && !ref_prev) : (!ref_lvl && ref_prev); // [R10]
        next_out      = current_sink_output;
        next_gs_count = gs_count;
        next_gs_done  = gs_done;
        if (ctrl[`BLANK_BIT]) begin
            next_out      = 3'h0; // [R3]
            next_gs_count = '0; // [R3]
            next_gs_done  = 1'b0; // [R3]
        end else if (pop && buf_mem[rd_ptr][`TIMING_RESET_EN_BIT]) begin
            next_out      = 3'h0; // [R7]
            next_gs_count = '0; // [R7]
            next_gs_done  = 1'b0; // [R5]
        end else if (gs_step) begin
            // Without timing reset a new word leaves the counter running.
            if (gs_done) begin
                next_out = 3'h0; // [R5]
            end else begin
                for (int i = 0; i < 3; i++) begin
                    next_out[i] = (gs_count < gray_val[i]); // [R16]
                end
                next_gs_count = gs_count + `GS_W'(1); // [R6] [R8]
                if ((gs_count == `GS_MAX) && !ctrl[`REPEAT_BIT]) begin
                    next_gs_done = 1'b1; // [R5]
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ref_prev            <= 1'b0;
            gs_count            <= '0;
            gs_done             <= 1'b0;
            current_sink_output <= 3'h0;
        end else begin
            ref_prev            <= ref_lvl;
            gs_count            <= next_gs_count;
            gs_done             <= next_gs_done;
            current_sink_output <= next_out;
        end
    end
endmodule : led_pwm_latch_control

// ==== src/led_pwm_params.svh ====
/*
 * Constants for the LED driver control-data latch and latch-pulse logic.
 * Assumes a 100 MHz system clock and an internal grayscale oscillator derived from it.
 */
// What this block does
// R1 - Latch keeps red3, green3, blue3 grayscale at bits 159-144, 175-160, 191-176.
// R2 - Latch keeps 7-bit brightness per colour at bits 198-192, 205-199, 212-206.
// R3 - Output-off bit 213 set forces outputs off, clears counter, initialises timing.
// R4 - After reset the output-off bit is one so all outputs start disabled.
// R5 - Repeat bit 214 clear: each output turns on once after unblank or timing reset.
// R6 - Repeat bit set: outputs repeat their on/off cycle every 65536 reference clocks.
// R7 - Timing-reset bit 215 set: latch pulse clears counter and forces outputs off.
// R8 - Timing-reset bit clear: latch pulse leaves counter running and outputs alone.
// R9 - Bit 216 selects reference: zero internal oscillator, one the shift clock.
// R10 - Bit 217 selects switching on rising edge when one, falling edge when zero.
// R11 - Latch pulse after idle of 8x last edge interval when top six bits equal 25h.
// R12 - Idle delay clamped between 8 and 16384 internal oscillator periods.
// R13 - A latch pulse copies the 218 low shift bits into the control latch.
// R14 - Each shift-clock rise shifts data into bit 0; bit 223 drives serial output.
// R15 - Controller holds shift clock static at least 8x last interval to latch.
// R16 - Output is on while the grayscale counter is below that channel's value.
// R17 - Edge interval is measured in internal oscillator periods.
`ifndef LED_PWM_PARAMS_SVH
`define LED_PWM_PARAMS_SVH

`define SHIFT_W          224
`define LATCH_W          218
`define CMD_W            6
`define CMD_CODE         6'h25
`define GS_W             16
`define BC_W             7
`define RED3_LSB         144
`define GREEN3_LSB       160
`define BLUE3_LSB        176
`define RED_BC_LSB       192
`define GREEN_BC_LSB     199
`define BLUE_BC_LSB      206
`define BLANK_BIT        213
`define REPEAT_BIT       214
`define TIMING_RESET_EN_BIT       215
`define CLKSEL_BIT       216
`define EDGESEL_BIT      217
`define GS_MAX           16'hFFFF
`define IDLE_MULT_SHIFT  3
`define IDLE_MIN_PERIODS 8
`define IDLE_MAX_PERIODS 16384
`define IVAL_W           15
`define THR_W            18
`define CLK_PERIOD_PS    10000
`define OSC_PERIOD_PS    83250
`define OSC_PERIOD_CYC   (`OSC_PERIOD_PS / `CLK_PERIOD_PS)
`define OSC_CNT_W        8

`endif

// ==== src/led_pwm_pkg.sv ====
/*
 * Types shared by the LED driver latch control logic.
 * Assumes the constants header is on the include path.
 */
`include "led_pwm_params.svh"

package led_pwm_pkg;
    typedef logic [`LATCH_W-1:0] latch_word_t;
    typedef logic [`SHIFT_W-1:0] shift_word_t;
    typedef logic [`GS_W-1:0]    gray_t;
    typedef logic [`BC_W-1:0]    bright_t;
endpackage : led_pwm_pkg

// ==== sim/led_pwm_latch_checker.sv ====
/*
 * Port checker for the LED latch control block, bound to every instance.
 * Assumes one sys_clk domain and a synchronous active-low reset held two cycles or more.
 */
`timescale 1ns/1ps
module led_pwm_latch_checker #(
    parameter int IDLE_MAX = 16384,
    parameter int OSC_DIV  = 8
) (
    // Clock and reset.
    input wire logic                 sys_clk,
    input wire logic                 resetn,
    // Serial link.
    input wire logic                 shift_clock_in,
    input wire logic                 serial_data_in,
    input wire logic                 serial_data_out,
    // Channel drive and brightness levels.
    input wire logic [2:0]           current_sink_output,
    input wire led_pwm_pkg::bright_t red_group_brightness,
    input wire led_pwm_pkg::bright_t green_group_brightness,
    input wire led_pwm_pkg::bright_t blue_group_brightness,
    // Status.
    input wire logic                 display_blanked,
    input wire logic                 latch_pulse
);
    import led_pwm_pkg::*;
    localparam int MIN_QUIET = 7 * OSC_DIV;
    logic        sck_q;
    logic [15:0] since_rise;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // Counts cycles since the last rise of the shift clock pin.
    always_ff @(posedge sys_clk) begin
        sck_q <= shift_clock_in;
        if (!resetn || (shift_clock_in && !sck_q)) since_rise <= 16'h0000;
        else if (since_rise != 16'hFFFF) since_rise <= since_rise + 16'h0001;
    end
    ////////////////////////////////////////
    chk_reset_blank: assert property ($rose(resetn) |-> display_blanked)
        else $error("outputs not blanked after reset");
    chk_blank_off: assert property (display_blanked && $past(display_blanked) |-> current_sink_output == 3'h0)
        else $error("output on while blanked");
    chk_unblank_on: assert property ($rose(|current_sink_output) |-> !$past(display_blanked))
        else $error("output rose out of blanking");
    chk_level_latch: assert property ($past(resetn) && $changed({red_group_brightness, green_group_brightness,
        blue_group_brightness}) |-> latch_pulse)
        else $error("brightness changed without latch");
    chk_blank_latch: assert property ($past(resetn) && $changed(display_blanked) |-> latch_pulse)
        else $error("blank changed without latch");
    chk_pulse_gap: assert property (latch_pulse |=> !latch_pulse [*8])
        else $error("latch pulse repeated");
    chk_sdo_quiet: assert property ($stable(shift_clock_in) [*8] |=> $stable(serial_data_out))
        else $error("serial out moved without shift");
    chk_idle_min: assert property (latch_pulse |-> since_rise >= 16'(MIN_QUIET))
        else $error("latch before minimum idle");
    cover property (latch_pulse);
    cover property ($fell(display_blanked));
    cover property ($rose(current_sink_output[0]));
endmodule : led_pwm_latch_checker

bind led_pwm_latch_control led_pwm_latch_checker #(.IDLE_MAX(IDLE_MAX), .OSC_DIV(OSC_DIV)) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .shift_clock_in(shift_clock_in), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .current_sink_output(current_sink_output),
    .red_group_brightness(red_group_brightness), .green_group_brightness(green_group_brightness),
    .blue_group_brightness(blue_group_brightness), .display_blanked(display_blanked), .latch_pulse(latch_pulse));

// ==== sim/led_host_model.sv ====
/*
 * Host link model: shifts one word MSB first at a 125 ns shift clock, then holds the link quiet.
 * Assumes the bench calls send_word and waits for the latch itself.
 */
`timescale 1ns/1ps
`include "led_pwm_params.svh"
module led_host_model (
    // Serial link.
    output logic shift_clock_in,
    output logic serial_data_in
);
    import led_pwm_pkg::*;
    initial begin
        shift_clock_in = 1'b0;
        serial_data_in = 1'b0;
    end
    task automatic send_word(input shift_word_t w);
        // Pin edges fall between system clock edges, so no pin ever changes on a sampling edge.
        #1.25;
        for (int i = `SHIFT_W - 1; i >= 0; i--) begin
            serial_data_in = w[i];
            #62.5 shift_clock_in = 1'b1;
            #62.5 shift_clock_in = 1'b0;
        end
        // Data is driven to the inverse of the last bit and the clock stands low so the device sees idle.
        serial_data_in = ~w[0];
    endtask : send_word
endmodule : led_host_model

// ==== sim/led_pwm_latch_control_tb.sv ====
/*
 * Bench for the LED latch control block: the host model shifts frames, checks are made at the ports.
 * Assumes the package, header and checker are compiled first.
 */
`timescale 1ns/1ps
`include "led_pwm_params.svh"
module led_pwm_latch_control_tb;
    import led_pwm_pkg::*;
    logic       sys_clk = 1'b0;
    logic       resetn  = 1'b0;
    logic       sck, sdi, sdo, blanked, pulse;
    logic [2:0] sink;
    bright_t    bc_r, bc_g, bc_b;
    int         bad_count = 0;
    int         tests_run = 0;
    always #5 sys_clk = ~sys_clk;
    led_host_model HOST (.shift_clock_in(sck), .serial_data_in(sdi));
    led_pwm_latch_control #(.IDLE_MAX(256), .OSC_DIV(8)) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .shift_clock_in(sck), .serial_data_in(sdi),
        .serial_data_out(sdo), .current_sink_output(sink), .red_group_brightness(bc_r),
        .green_group_brightness(bc_g), .blue_group_brightness(bc_b), .display_blanked(blanked),
        .latch_pulse(pulse));
    ////////////////////////////////////////
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    function automatic shift_word_t mk(logic [5:0] c, logic [4:0] fc, bright_t bb, bright_t gb, bright_t rb,
        gray_t bl, gray_t r);
        mk = {c, fc, bb, gb, rb, bl, 16'h0000, r, 144'h0};
    endfunction : mk
    // Shifts one word, then waits a bounded time for the latch pulse.
    task automatic frame(input shift_word_t w, input logic exp);
        logic seen;
        seen = 1'b0;
        HOST.send_word(w);
        for (int i = 0; i < 3000 && !(seen && exp); i++) begin
            @(negedge sys_clk);
            if (pulse === 1'b1) seen = 1'b1;
        end
        chk(seen, exp);
        chk(sdo, w[223]);
        if (seen !== exp) final_report();
    endtask : frame
    ////////////////////////////////////////
    initial begin
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        chk(blanked, 1'b1);
        chk(sink, 3'h0);
        // Internal reference, rising edge, repeat on, unblanked.
        frame(mk(6'h25, 5'h12, 7'h7F, 7'h2A, 7'h55, 16'hFFFF, 16'h0040), 1'b1);
        chk(bc_r, 7'h55);
        chk(bc_g, 7'h2A);
        chk(bc_b, 7'h7F);
        chk(blanked, 1'b0);
        repeat (100) @(negedge sys_clk);
        chk(sink, 3'h5);
        repeat (900) @(negedge sys_clk);
        chk(sink, 3'h4);
        // Shift clock reference standing still, no timing reset: outputs hold.
        frame(mk(6'h25, 5'h1A, 7'h03, 7'h02, 7'h01, 16'hFFFF, 16'hFFFF), 1'b1);
        repeat (200) @(negedge sys_clk);
        chk(sink, 3'h4);
        chk(bc_r, 7'h01);
        // Timing reset: the latch forces every output off.
        frame(mk(6'h25, 5'h1E, 7'h03, 7'h02, 7'h01, 16'hFFFF, 16'hFFFF), 1'b1);
        repeat (200) @(negedge sys_clk);
        chk(sink, 3'h0);
        // Blank set again.
        frame(mk(6'h25, 5'h1F, 7'h10, 7'h20, 7'h30, 16'hFFFF, 16'hFFFF), 1'b1);
        chk(blanked, 1'b1);
        chk(sink, 3'h0);
        // Wrong command code: nothing is latched.
        frame(mk(6'h05, 5'h00, 7'h7F, 7'h7F, 7'h7F, 16'h0000, 16'h0000), 1'b0);
        chk(bc_r, 7'h30);
        chk(blanked, 1'b1);
        // Internal reference, falling edge, unblanked again by a new word.
        frame(mk(6'h25, 5'h02, 7'h01, 7'h02, 7'h03, 16'h0000, 16'h0010), 1'b1);
        chk(blanked, 1'b0);
        chk(bc_g, 7'h02);
        repeat (50) @(negedge sys_clk);
        chk(sink, 3'h1);
        repeat (200) @(negedge sys_clk);
        chk(sink, 3'h0);
        final_report();
    end
endmodule : led_pwm_latch_control_tb
